// File: ssa_alu.sv
// Package of shared constants and the arithmetic unit for the subtract/swap core.
// Assumes one clock domain; the unit itself is purely combinational.
`timescale 1ns/100ps
`default_nettype none

package ssa_pkg;
  // Clock and the quarter-phase divider
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QUARTER_CYCLES = 1;
  // Instruction word fields
  localparam int unsigned IW_WIDTH       = 14;
  localparam int unsigned OPC_HI         = 13;
  localparam int unsigned OPC_LO         = 8;
  localparam int unsigned DEST_BIT       = 7;
  localparam int unsigned FADDR_WIDTH    = 7;
  localparam int unsigned BANK_WIDTH     = 2;
  localparam int unsigned FILE_DEPTH     = 512;
  localparam logic [5:0]  OPC_SUB_FILE   = 6'h02;
  localparam logic [5:0]  OPC_SWAP_FILE  = 6'h0e;
  localparam logic [4:0]  OPC_SUB_LIT    = 5'h1e;
  localparam logic        DEST_ACC       = 1'b0;
  localparam logic        DEST_FILE      = 1'b1;
  // Software port map
  localparam int unsigned BUS_AW         = 10;
  localparam logic [9:0]  ADDR_ACC       = 10'h200;
  localparam logic [9:0]  ADDR_STATUS    = 10'h201;
  localparam int unsigned ST_CARRY       = 0;
  localparam int unsigned ST_DCARRY      = 1;
  localparam int unsigned ST_ZERO        = 2;
  // Values after reset
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic        FLAG_RESET     = 1'b0;

  typedef enum logic [1:0] {
    SSA_Q1 = 2'b00,
    SSA_Q2 = 2'b01,
    SSA_Q3 = 2'b11,
    SSA_Q4 = 2'b10
  } ssa_phase_e;

  typedef enum logic [1:0] {
    SSA_OP_NONE = 2'b00,
    SSA_OP_SUBL = 2'b01,
    SSA_OP_SUBF = 2'b11,
    SSA_OP_SWAP = 2'b10
  } ssa_op_e;
endpackage : ssa_pkg

module ssa_alu
  import ssa_pkg::*;
(
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] acc,
  input  wire logic       do_swap,
  output logic [7:0]      result,
  output logic            carry,
  output logic            dcarry,
  output logic            zero
);
  logic [8:0] diff;

  always_comb begin
    diff   = {1'b0, minuend} - {1'b0, acc};
    // Carry reads as inverted borrow: set when no underflow
    carry  = ~diff[8];
    dcarry = (minuend[3:0] >= acc[3:0]);
    if (do_swap) begin
      result = {minuend[3:0], minuend[7:4]};
    end else begin
      result = diff[7:0];
    end
    zero = (result == 8'h00);
  end
endmodule : ssa_alu

`default_nettype wire

// File: ssa_core.sv
// Execution core for literal subtract, file subtract and nibble swap.
// Assumes instructions come from logic on sys_clk; file registers and accumulator
// are also reachable over a simple strobe port with read data one cycle later.
//
// Behaviour
// - Literal subtract decodes in Q1, takes the literal in Q2, computes in Q3, writes the accumulator in Q4.
// - A subtraction with a positive result sets the carry flag, which is an inverted borrow.
// - A subtraction with a zero result sets carry to one and stores zero in the destination.
// - An underflowing subtraction clears carry and stores the wrapped eight-bit difference.
// - File subtract is decoded from 00 0010, a destination bit and a seven-bit address.
// - File subtract stores register minus accumulator in the accumulator for d=0, else in the register.
// - File subtract updates carry, digit carry and zero and no other status bit.
// - Nibble swap exchanges the two halves of the register and leaves all flags alone.
// - Nibble swap is decoded from 00 1110, a destination bit and seven address bits, routed like subtract.
// - File subtract and swap take one instruction cycle and write the destination in Q4.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module ssa_core
  import ssa_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic [IW_WIDTH-1:0]   instr_word,
  input  wire logic                  instr_valid,
  input  wire logic [BANK_WIDTH-1:0] bank_sel,
  input  wire logic [BUS_AW-1:0]     bus_addr,
  input  wire logic [7:0]            bus_wdata,
  input  wire logic                  bus_we,
  input  wire logic                  bus_re,
  output logic [7:0]                 bus_rdata,
  output logic                       instr_ready,
  output logic                       instr_done,
  output logic                       instr_illegal,
  output logic [7:0]                 acc_out,
  output logic                       carry_flag,
  output logic                       digit_carry_flag,
  output logic                       zero_flag
);
  localparam int unsigned MEM_AW = BANK_WIDTH + FADDR_WIDTH;

  ssa_phase_e       phase_r;
  ssa_phase_e       phase_nxt;
  ssa_op_e          op_r;
  ssa_op_e          op_nxt;
  logic             act_r;
  logic             dest_r;
  logic [MEM_AW-1:0] maddr_r;
  logic [7:0]       lit_r;
  logic [7:0]       opnd_r;
  logic [7:0]       res_r;
  logic             c_res_r;
  logic             dcarry_res_r;
  logic             z_res_r;
  logic [7:0]       acc_r;
  logic             carry_r;
  logic             dcarry_r;
  logic             zero_r;
  logic             ready_r;
  logic             done_r;
  logic             illegal_r;
  logic [7:0]       rdata_r;
  logic [7:0]       file_mem [FILE_DEPTH];

  logic [7:0]       alu_res;
  logic             alu_c;
  logic             alu_dcarry;
  logic             alu_z;
  logic             is_sub;
  logic             core_wr_file;
  logic             core_wr_acc;
  logic             bus_wr_acc;
  logic             bus_wr_st;
  logic             bus_wr_mem;
  logic             take;

  assign is_sub       = (op_r == SSA_OP_SUBL) || (op_r == SSA_OP_SUBF);
  assign take         = (phase_r == SSA_Q1) && instr_valid;
  assign core_wr_file = act_r && (phase_r == SSA_Q4) && (op_r != SSA_OP_SUBL) && (dest_r == DEST_FILE);
  assign core_wr_acc  = act_r && (phase_r == SSA_Q4) && ((op_r == SSA_OP_SUBL) || (dest_r == DEST_ACC));
  assign bus_wr_acc   = bus_we && (bus_addr == ADDR_ACC);
  assign bus_wr_st    = bus_we && (bus_addr == ADDR_STATUS);
  assign bus_wr_mem   = bus_we && (bus_addr < BUS_AW'(FILE_DEPTH));

  // Quarter phases: one per clock, Gray sequence Q1 Q2 Q3 Q4
  always_comb begin
    case (phase_r)
      SSA_Q1:  phase_nxt = SSA_Q2;
      SSA_Q2:  phase_nxt = SSA_Q3;
      SSA_Q3:  phase_nxt = SSA_Q4;
      SSA_Q4:  phase_nxt = SSA_Q1;
      default: phase_nxt = SSA_Q1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_r <= SSA_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Ready is high in each Q1 except the first after reset; Q1 is the only phase an instruction is taken
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (phase_nxt == SSA_Q1);
    end
  end

  always_comb begin
    if (instr_word[OPC_HI:OPC_LO] == OPC_SUB_FILE) begin
      op_nxt = SSA_OP_SUBF;
    end else if (instr_word[OPC_HI:OPC_LO] == OPC_SWAP_FILE) begin
      op_nxt = SSA_OP_SWAP;
    end else if (instr_word[OPC_HI:OPC_LO+1] == OPC_SUB_LIT) begin
      op_nxt = SSA_OP_SUBL;
    end else begin
      op_nxt = SSA_OP_NONE;
    end
  end

  // Decode in Q1; instruction held for the whole cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      act_r   <= 1'b0;
      op_r    <= SSA_OP_NONE;
      dest_r  <= DEST_ACC;
      maddr_r <= '0;
      lit_r   <= 8'h00;
    end else if (phase_r == SSA_Q1) begin
      act_r   <= take && (op_nxt != SSA_OP_NONE);
      op_r    <= take ? op_nxt : SSA_OP_NONE;
      dest_r  <= instr_word[DEST_BIT];
      maddr_r <= {bank_sel, instr_word[FADDR_WIDTH-1:0]};
      lit_r   <= instr_word[7:0];
    end
  end

  // Literal or addressed register fetched in Q2
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opnd_r <= 8'h00;
    end else if (phase_r == SSA_Q2) begin
      opnd_r <= (op_r == SSA_OP_SUBL) ? lit_r : file_mem[maddr_r];
    end
  end

  ssa_alu u_alu (
    .minuend (opnd_r),
    .acc     (acc_r),
    .do_swap (op_r == SSA_OP_SWAP),
    .result  (alu_res),
    .carry   (alu_c),
    .dcarry  (alu_dcarry),
    .zero    (alu_z)
  );

  // Result captured in Q3 so Q4 only writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_r        <= 8'h00;
      c_res_r      <= 1'b0;
      dcarry_res_r <= 1'b0;
      z_res_r      <= 1'b0;
    end else if (phase_r == SSA_Q3) begin
      res_r        <= alu_res;
      c_res_r      <= alu_c;
      dcarry_res_r <= alu_dcarry;
      z_res_r      <= alu_z;
    end
  end

  // Accumulator destination written in Q4; core beats the port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_r <= ACC_RESET;
    end else if (core_wr_acc) begin
      acc_r <= res_r;
    end else if (bus_wr_acc) begin
      acc_r <= bus_wdata;
    end
  end

  // Flags follow subtract only; swap leaves them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      carry_r  <= FLAG_RESET;
      dcarry_r <= FLAG_RESET;
      zero_r   <= FLAG_RESET;
    end else if (act_r && (phase_r == SSA_Q4) && is_sub) begin
      carry_r  <= c_res_r;
      dcarry_r <= dcarry_res_r;
      zero_r   <= z_res_r;
    end else if (bus_wr_st) begin
      carry_r  <= bus_wdata[ST_CARRY];
      dcarry_r <= bus_wdata[ST_DCARRY];
      zero_r   <= bus_wdata[ST_ZERO];
    end
  end

  // File destination; same-address clash resolves to the core
  always_ff @(posedge sys_clk) begin
    if (bus_wr_mem) begin
      file_mem[bus_addr[MEM_AW-1:0]] <= bus_wdata;
    end
    if (core_wr_file) begin
      file_mem[maddr_r] <= res_r;
    end
  end

  // Completion pulses: done one cycle after the Q4 write, illegal one cycle after the Q1 take
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      done_r    <= act_r && (phase_r == SSA_Q4);
      illegal_r <= take && (op_nxt == SSA_OP_NONE);
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (bus_re) begin
      if (bus_addr < BUS_AW'(FILE_DEPTH)) begin
        rdata_r <= file_mem[bus_addr[MEM_AW-1:0]];
      end else if (bus_addr == ADDR_ACC) begin
        rdata_r <= acc_r;
      end else if (bus_addr == ADDR_STATUS) begin
        rdata_r <= {5'h00, zero_r, dcarry_r, carry_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign bus_rdata        = rdata_r;
  assign instr_ready      = ready_r;
  assign instr_done       = done_r;
  assign instr_illegal    = illegal_r;
  assign acc_out          = acc_r;
  assign carry_flag       = carry_r;
  assign digit_carry_flag = dcarry_r;
  assign zero_flag        = zero_r;

  // Checks kept beside the logic
  logic st_free;
  logic acc_free;
  assign st_free  = !bus_wr_st;
  assign acc_free = !bus_wr_acc;

  phase_walk_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (phase_r == SSA_Q1) |=> (phase_r == SSA_Q2) ##1 (phase_r == SSA_Q3) ##1 (phase_r == SSA_Q4)
  ) else $error("quarter phases out of order");

  literal_acc_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && op_nxt == SSA_OP_SUBL) |-> ##4 (acc_r == 8'($past(lit_r, 2) - $past(acc_r, 1)))
  ) else $error("literal subtract result wrong");

  carry_positive_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q4 && is_sub && opnd_r > $past(acc_r, 1)) |=> carry_r && !zero_r
  ) else $error("carry not set on positive result");

  zero_result_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q3 && is_sub && opnd_r == acc_r) |-> ##2 (carry_r && zero_r)
  ) else $error("zero result flags wrong");

  borrow_clear_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q3 && is_sub && opnd_r < acc_r) |-> ##2 (!carry_r && !zero_r)
  ) else $error("carry not cleared on underflow");

  decode_subf_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && instr_word[OPC_HI:OPC_LO] == OPC_SUB_FILE) |=> (op_r == SSA_OP_SUBF) && act_r
  ) else $error("file subtract not decoded");

  dest_file_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (core_wr_file && acc_free) |=> $stable(acc_r) && (file_mem[$past(maddr_r)] == $past(res_r))
  ) else $error("file destination misrouted");

  swap_flags_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q4 && op_r == SSA_OP_SWAP && st_free) |=> $stable({carry_r, dcarry_r, zero_r})
  ) else $error("swap touched the flags");

  swap_value_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q4 && op_r == SSA_OP_SWAP && dest_r == DEST_ACC)
      |=> acc_r == {$past(opnd_r[3:0]), $past(opnd_r[7:4])}
  ) else $error("swap result wrong");

  done_timing_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && op_nxt != SSA_OP_NONE) |-> ##1 !instr_done [*3] ##1 instr_done
  ) else $error("instruction not done in one cycle");

  ready_q1_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (phase_r == SSA_Q4) |=> instr_ready
  ) else $error("ready missing in Q1");

  ready_idle_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (phase_r != SSA_Q1) |-> !instr_ready
  ) else $error("ready outside Q1");

  illegal_word_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && op_nxt == SSA_OP_NONE) |=> instr_illegal && !act_r
  ) else $error("undecodable word not flagged");

  decode_subl_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && instr_word[OPC_HI:OPC_LO+1] == OPC_SUB_LIT) |=> (op_r == SSA_OP_SUBL) && act_r
  ) else $error("literal subtract not decoded");

  decode_swap_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (take && instr_word[OPC_HI:OPC_LO] == OPC_SWAP_FILE) |=> (op_r == SSA_OP_SWAP) && act_r
  ) else $error("nibble swap not decoded");

  digit_carry_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q3 && is_sub) |-> ##2 (dcarry_r == $past(opnd_r[3:0] >= acc_r[3:0], 2))
  ) else $error("digit carry wrong");

  swap_file_a: assert property (
    @(posedge sys_clk) disable iff (reset)
    (act_r && phase_r == SSA_Q4 && op_r == SSA_OP_SWAP && dest_r == DEST_FILE)
      |=> file_mem[$past(maddr_r)] == {$past(opnd_r[3:0]), $past(opnd_r[7:4])}
  ) else $error("swap file result wrong");

endmodule : ssa_core

`default_nettype wire

// File: ssa_core_tb.sv
// Self-checking bench for ssa_core: port preload, directed and random instructions.
// Assumes the core alone on one 50 MHz clock; the strobe port stays idle while an instruction runs.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  import ssa_pkg::*;
  logic                  sys_clk, reset, instr_valid, bus_we, bus_re;
  logic [IW_WIDTH-1:0]   instr_word, w;
  logic [BANK_WIDTH-1:0] bank_sel, b;
  logic [BUS_AW-1:0]     bus_addr;
  logic [7:0]            bus_wdata, bus_rdata, acc_out, rd, acc_m;
  logic                  instr_ready, instr_done, instr_illegal, carry_flag, digit_carry_flag, zero_flag;
  logic                  c_m, dcarry_m, z_m;
  logic [7:0]            mem_m [FILE_DEPTH];
  int                    fail_count, num_checks;

  ssa_core uut (
    .sys_clk(sys_clk), .reset(reset), .instr_word(instr_word), .instr_valid(instr_valid),
    .bank_sel(bank_sel), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
    .bus_re(bus_re), .bus_rdata(bus_rdata), .instr_ready(instr_ready), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .acc_out(acc_out), .carry_flag(carry_flag),
    .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag)
  );

  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  task bus_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_we    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_we    <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_re   <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_re   <= 1'b0;
    @(negedge sys_clk);
    d = bus_rdata;
  endtask : bus_rd

  task automatic sub_m(input logic [7:0] a, output logic [7:0] r);
    r    = a - acc_m;
    c_m  = (a >= acc_m);
    dcarry_m = (a[3:0] >= acc_m[3:0]);
    z_m  = (r == 8'h00);
  endtask : sub_m

  task automatic exec(input logic [13:0] wd, input logic [1:0] bk);
    int         k;
    int         idx;
    logic [7:0] r;
    logic [7:0] acc_o;
    logic       ok;
    idx   = int'(bk) * 128 + int'(wd[6:0]);
    ok    = 1'b1;
    acc_o = acc_m;
    if (wd[13:9] == OPC_SUB_LIT) begin
      sub_m(wd[7:0], r);
      acc_m = r;
    end else if (wd[13:8] == OPC_SUB_FILE || wd[13:8] == OPC_SWAP_FILE) begin
      if (wd[13:8] == OPC_SUB_FILE) sub_m(mem_m[idx], r);
      else r = {mem_m[idx][3:0], mem_m[idx][7:4]};
      if (wd[DEST_BIT] == DEST_FILE) mem_m[idx] = r;
      else acc_m = r;
    end else begin
      ok = 1'b0;
    end
    // Valid raised early on purpose: outside Q1 it must be ignored
    @(posedge sys_clk);
    instr_word  <= wd;
    bank_sel    <= bk;
    instr_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 10);
    instr_valid <= 1'b0;
    if (k >= 10) fail_count++;
    @(negedge sys_clk);
    `CHK("instr_illegal", ~ok, instr_illegal)
    `CHK("ready outside Q1", 1'b0, instr_ready)
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("acc before Q4", acc_o, acc_out)
    `CHK("done before Q4", 1'b0, instr_done)
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("instr_done", ok, instr_done)
    `CHK("ready in next Q1", 1'b1, instr_ready)
    `CHK("acc_out", acc_m, acc_out)
    `CHK("carry_flag", c_m, carry_flag)
    `CHK("digit_carry_flag", dcarry_m, digit_carry_flag)
    `CHK("zero_flag", z_m, zero_flag)
    if (ok && wd[DEST_BIT] == DEST_FILE && wd[13:9] != OPC_SUB_LIT) begin
      bus_rd(10'(idx), r);
      `CHK("file result", mem_m[idx], r)
    end
  endtask : exec

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  initial begin
    reset       = 1'b1;
    instr_valid = 1'b0;
    instr_word  = '0;
    bank_sel    = '0;
    bus_we      = 1'b0;
    bus_re      = 1'b0;
    bus_addr    = '0;
    bus_wdata   = '0;
    fail_count  = 0;
    num_checks  = 0;
    acc_m       = ACC_RESET;
    c_m         = FLAG_RESET;
    dcarry_m    = FLAG_RESET;
    z_m         = FLAG_RESET;
    void'($urandom(47920));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    bus_rd(ADDR_STATUS, rd);
    `CHK("status after reset", 8'h00, rd)
    `CHK("acc after reset", ACC_RESET, acc_out)
    for (int i = 0; i < FILE_DEPTH; i++) begin
      mem_m[i] = 8'($urandom);
      bus_wr(10'(i), mem_m[i]);
    end
    bus_wr(10'h3ff, 8'h5a);
    bus_rd(10'h3ff, rd);
    `CHK("unmapped read", 8'h00, rd)
    // literal 2 minus 1, 2, 3
    for (int i = 1; i <= 3; i++) begin
      bus_wr(ADDR_ACC, 8'(i));
      acc_m = 8'(i);
      exec({OPC_SUB_LIT, 1'b0, 8'h02}, 2'b00);
    end
    // register 3, 2, 1 minus 2 at top address of each bank
    for (int i = 0; i < 6; i++) begin
      b = 2'(i);
      mem_m[int'(b) * 128 + 127] = 8'(3 - i % 3);
      bus_wr({1'b0, b, 7'h7f}, 8'(3 - i % 3));
      bus_wr(ADDR_ACC, 8'h02);
      acc_m = 8'h02;
      exec({OPC_SUB_FILE, 1'(i / 3), 7'h7f}, b);
    end
    // swap of a5 to both destinations
    for (int i = 0; i < 2; i++) begin
      mem_m[10] = 8'ha5;
      bus_wr(10'd10, 8'ha5);
      exec({OPC_SWAP_FILE, 1'(i), 7'h0a}, 2'b00);
    end
    exec(14'h0700, 2'b01);
    for (int i = 0; i < 80; i++) begin
      w = 14'($urandom);
      b = 2'($urandom);
      case ($urandom_range(0, 3))
        0: w[13:9] = OPC_SUB_LIT;
        1: w[13:8] = OPC_SUB_FILE;
        2: w[13:8] = OPC_SWAP_FILE;
        default: w[13:8] = 6'h07;
      endcase
      exec(w, b);
    end
    conclude();
  end
endmodule : testbench

`default_nettype wire
